// [core/pin_function_defines.vh]
// Offsets, field layouts, reset values and codes of the pin function selector
`ifndef PIN_FUNCTION_DEFINES_VH
`define PIN_FUNCTION_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PORT_A_LOW_CTRL_1 5'h00
`define OFS_PORT_B_LOW_CTRL_1 5'h04
`define OFS_PORT_B_HIGH_CTRL 5'h08
`define OFS_PORT_C_LOW_CTRL 5'h0C
`define OFS_PIN_STATUS 5'h10

// ----------------------------------------
// Writable bit masks
// ----------------------------------------
`define MASK_FOUR_FIELDS 16'h7777
`define MASK_UPPER_FIELD 16'h0700
`define MASK_TWO_LOW_FIELDS 16'h0077

// ----------------------------------------
// Reset values and boot-dependent bits
// ----------------------------------------
`define RESET_CTRL 16'h0000
`define BOOT_BITS_PORT_B_LOW 16'h0011
`define BOOT_BITS_PORT_B_HIGH 16'h0100
`define BOOT_BITS_PORT_C_LOW 16'h0011
`define BOOT_LOAD_CYCLE 2'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FIELD_LINE3_LSB 12
`define FIELD_LINE6_LSB 8
`define FIELD_LINE5_LSB 4
`define FIELD_LINE4_LSB 0

// ----------------------------------------
// Function codes
// ----------------------------------------
`define CODE_PORT 3'h0
`define CODE_ONE 3'h1
`define CODE_TWO 3'h2
`define CODE_THREE 3'h3
`define CODE_FOUR 3'h4
`define CODE_FIVE 3'h5
`define CODE_SEVEN 3'h7

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [core/port_pin_function_select.v]
// Pin function selector for multiplexed port pins, AXI4-Lite register slave
// Operation
// - Port A line 3 field 14:12: port, chip select 3, serial 1 rx, sync serial
// - Emulator select low forces port A line 3 to test mode select input
// - Reserved control bits read zero; software writes zero to them
// - Port B line 6 field 10:8: port, A18, bus ack, interrupt_request_five_in, disable3, rx0
// - Boot-marked bits reset to one in ROM-less external mode, else zero
// - Port C line 5 field 6:4: port or address bit 5 output
// - Port C line 4 field 2:0: port or address bit 4 output
// - Port A low register 1: four fields, gaps read zero, resets zero
// - Port B low register 1: same layout, bits 4 and 0 boot-dependent
`timescale 1ns/100ps
`include "pin_function_defines.vh"

module port_pin_function_select
(
	input wire sys_clk,
	input wire rst_b,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext_rom_disabled_strap,
	input wire emulator_select_input_n,
	input wire pa3_pin_in,
	output reg pa3_pin_out,
	output reg pa3_pin_oe,
	input wire pb6_pin_in,
	output reg pb6_pin_out,
	output reg pb6_pin_oe,
	input wire pc5_pin_in,
	output reg pc5_pin_out,
	output reg pc5_pin_oe,
	input wire pc4_pin_in,
	output reg pc4_pin_out,
	output reg pc4_pin_oe,
	input wire pa3_port_out,
	input wire pa3_port_oe,
	output reg pa3_port_in,
	input wire chip_select_three_out,
	output reg serial_one_receive_in,
	input wire sync_serial_data_out,
	input wire sync_serial_data_oe,
	output reg sync_serial_data_in,
	output reg test_mode_select_in,
	input wire pb6_port_out,
	input wire pb6_port_oe,
	output reg pb6_port_in,
	input wire address_bit_eighteen,
	output reg bus_ack_in,
	output reg interrupt_request_five_in,
	input wire output_disable_three_out,
	input wire output_disable_three_oe,
	output reg output_disable_three_in,
	output reg serial_zero_receive_in,
	input wire pc5_port_out,
	input wire pc5_port_oe,
	output reg pc5_port_in,
	input wire address_bit_five,
	input wire pc4_port_out,
	input wire pc4_port_oe,
	output reg pc4_port_in,
	input wire address_bit_four
);

// ----------------------------------------
// Helpers
// ----------------------------------------
function [15:0] merge_write;
	input [15:0] old;
	input [31:0] data;
	input [3:0] strb;
	input [15:0] mask;
	reg [15:0] lanes;
	begin
		lanes = {{8{strb[1]}}, {8{strb[0]}}};
		merge_write = ((old & ~lanes) | (data[15:0] & lanes)) & mask;
	end
endfunction

function [2:0] field_at;
	input [15:0] reg_value;
	input integer lsb;
	begin
		field_at = reg_value[lsb +: 3];
	end
endfunction

// ----------------------------------------
// Pin synchronisers and boot capture
// ----------------------------------------
reg [5:0] sync_1_q;
reg [5:0] sync_2_q;
reg [1:0] boot_cnt_q;
reg boot_done_q;
reg boot_ext_q;
wire pa3_s = sync_2_q[0];
wire pb6_s = sync_2_q[1];
wire pc5_s = sync_2_q[2];
wire pc4_s = sync_2_q[3];
wire emu_sel_n_s = sync_2_q[4];
wire strap_s = sync_2_q[5];
wire boot_load = !boot_done_q && (boot_cnt_q == `BOOT_LOAD_CYCLE);

always @(posedge sys_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		// Idle-high start so no false pin level follows reset
		sync_1_q <= 6'h3F;
		sync_2_q <= 6'h3F;
		boot_cnt_q <= 2'h0;
		{boot_done_q, boot_ext_q} <= 2'h0;
	end
	else
	begin
		sync_1_q <= {ext_rom_disabled_strap, emulator_select_input_n,
			pc4_pin_in, pc5_pin_in, pb6_pin_in, pa3_pin_in};
		sync_2_q <= sync_1_q;
		if (!boot_done_q)
			boot_cnt_q <= boot_cnt_q + 2'h1;
		if (boot_load)
			{boot_done_q, boot_ext_q} <= {1'b1, strap_s};
	end
end

// ----------------------------------------
// Control registers
// ----------------------------------------
reg [15:0] port_a_low_function_ctrl_1_q;
reg [15:0] port_b_low_function_ctrl_1_q;
reg [15:0] port_b_high_function_ctrl_q;
reg [15:0] port_c_low_function_ctrl_q;
reg aw_held_q;
reg [4:0] aw_addr_q;
reg w_held_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;
wire aw_take = s_axi_awvalid && s_axi_awready;
wire w_take = s_axi_wvalid && s_axi_wready;
wire commit = aw_held_q && w_held_q && !s_axi_bvalid;
wire b_done = s_axi_bvalid && s_axi_bready;
wire aw_held_d = (aw_held_q || aw_take) && !commit;
wire w_held_d = (w_held_q || w_take) && !commit;
wire bvalid_d = commit || (s_axi_bvalid && !b_done);
wire wr_hit = (aw_addr_q <= `OFS_PIN_STATUS) && (aw_addr_q[1:0] == 2'h0);

always @(posedge sys_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		port_a_low_function_ctrl_1_q <= `RESET_CTRL;
		port_b_low_function_ctrl_1_q <= `RESET_CTRL;
		port_b_high_function_ctrl_q <= `RESET_CTRL;
		port_c_low_function_ctrl_q <= `RESET_CTRL;
		{aw_held_q, w_held_q} <= 2'h0;
		aw_addr_q <= 5'h00;
		w_data_q <= 32'h00000000;
		w_strb_q <= 4'h0;
		{s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'h0;
		s_axi_bresp <= `RESP_OKAY;
	end
	else
	begin
		if (boot_load && strap_s)
		begin
			port_b_low_function_ctrl_1_q <= `BOOT_BITS_PORT_B_LOW;
			port_b_high_function_ctrl_q <= `BOOT_BITS_PORT_B_HIGH;
			port_c_low_function_ctrl_q <= `BOOT_BITS_PORT_C_LOW;
		end
		if (aw_take)
			aw_addr_q <= s_axi_awaddr;
		if (w_take)
		begin
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
		aw_held_q <= aw_held_d;
		w_held_q <= w_held_d;
		s_axi_awready <= boot_done_q && !aw_held_d && !bvalid_d;
		s_axi_wready <= boot_done_q && !w_held_d && !bvalid_d;
		s_axi_bvalid <= bvalid_d;
		if (commit)
		begin
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			case (aw_addr_q)
				`OFS_PORT_A_LOW_CTRL_1: port_a_low_function_ctrl_1_q <=
					merge_write(port_a_low_function_ctrl_1_q, w_data_q,
					w_strb_q, `MASK_FOUR_FIELDS);
				`OFS_PORT_B_LOW_CTRL_1: port_b_low_function_ctrl_1_q <=
					merge_write(port_b_low_function_ctrl_1_q, w_data_q,
					w_strb_q, `MASK_FOUR_FIELDS);
				`OFS_PORT_B_HIGH_CTRL: port_b_high_function_ctrl_q <=
					merge_write(port_b_high_function_ctrl_q, w_data_q,
					w_strb_q, `MASK_UPPER_FIELD);
				`OFS_PORT_C_LOW_CTRL: port_c_low_function_ctrl_q <=
					merge_write(port_c_low_function_ctrl_q, w_data_q,
					w_strb_q, `MASK_TWO_LOW_FIELDS);
				default: ;
			endcase
		end
	end
end

// ----------------------------------------
// Read channel
// ----------------------------------------
wire ar_take = s_axi_arvalid && s_axi_arready;
wire r_done = s_axi_rvalid && s_axi_rready;
wire rvalid_d = ar_take || (s_axi_rvalid && !r_done);
reg [31:0] rd_value;
reg rd_hit;

always @*
begin
	rd_hit = 1'b1;
	case (s_axi_araddr)
		`OFS_PORT_A_LOW_CTRL_1: rd_value = {16'h0000, port_a_low_function_ctrl_1_q};
		`OFS_PORT_B_LOW_CTRL_1: rd_value = {16'h0000, port_b_low_function_ctrl_1_q};
		`OFS_PORT_B_HIGH_CTRL: rd_value = {16'h0000, port_b_high_function_ctrl_q};
		`OFS_PORT_C_LOW_CTRL: rd_value = {16'h0000, port_c_low_function_ctrl_q};
		`OFS_PIN_STATUS: rd_value = {29'h0, boot_done_q, boot_ext_q, !emu_sel_n_s};
		default: {rd_hit, rd_value} = {1'b0, 32'h00000000};
	endcase
end

always @(posedge sys_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		{s_axi_arready, s_axi_rvalid} <= 2'h0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `RESP_OKAY;
	end
	else
	begin
		s_axi_arready <= boot_done_q && !rvalid_d;
		s_axi_rvalid <= rvalid_d;
		if (ar_take)
		begin
			s_axi_rdata <= rd_value;
			s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
	end
end

// ----------------------------------------
// Pin routing
// ----------------------------------------
wire [2:0] pa3_fn = field_at(port_a_low_function_ctrl_1_q, `FIELD_LINE3_LSB);
wire [2:0] pb6_fn = field_at(port_b_high_function_ctrl_q, `FIELD_LINE6_LSB);
wire [2:0] pc5_fn = field_at(port_c_low_function_ctrl_q, `FIELD_LINE5_LSB);
wire [2:0] pc4_fn = field_at(port_c_low_function_ctrl_q, `FIELD_LINE4_LSB);
reg pa3_out_d;
reg pa3_oe_d;
reg pb6_out_d;
reg pb6_oe_d;
reg pc5_out_d;
reg pc5_oe_d;
reg pc4_out_d;
reg pc4_oe_d;

always @*
begin
	// Prohibited codes leave the pin undriven
	{pa3_out_d, pa3_oe_d} = 2'h0;
	if (emu_sel_n_s)
	begin
		case (pa3_fn)
			`CODE_PORT: {pa3_out_d, pa3_oe_d} = {pa3_port_out, pa3_port_oe};
			`CODE_ONE: {pa3_out_d, pa3_oe_d} = {chip_select_three_out, 1'b1};
			`CODE_SEVEN: {pa3_out_d, pa3_oe_d} =
				{sync_serial_data_out, sync_serial_data_oe};
			default: ;
		endcase
	end
	{pb6_out_d, pb6_oe_d} = 2'h0;
	case (pb6_fn)
		`CODE_PORT: {pb6_out_d, pb6_oe_d} = {pb6_port_out, pb6_port_oe};
		`CODE_ONE: {pb6_out_d, pb6_oe_d} = {address_bit_eighteen, 1'b1};
		`CODE_FOUR: {pb6_out_d, pb6_oe_d} =
			{output_disable_three_out, output_disable_three_oe};
		default: ;
	endcase
	pc5_out_d = (pc5_fn == `CODE_ONE) ? address_bit_five : pc5_port_out;
	pc5_oe_d = (pc5_fn == `CODE_ONE) | ((pc5_fn == `CODE_PORT) & pc5_port_oe);
	pc4_out_d = (pc4_fn == `CODE_ONE) ? address_bit_four : pc4_port_out;
	pc4_oe_d = (pc4_fn == `CODE_ONE) | ((pc4_fn == `CODE_PORT) & pc4_port_oe);
end

always @(posedge sys_clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		{pa3_pin_out, pa3_pin_oe, pb6_pin_out, pb6_pin_oe} <= 4'h0;
		{pc5_pin_out, pc5_pin_oe, pc4_pin_out, pc4_pin_oe} <= 4'h0;
		{pa3_port_in, pb6_port_in, pc5_port_in, pc4_port_in} <= 4'hF;
		{serial_one_receive_in, sync_serial_data_in, test_mode_select_in} <= 3'h7;
		{bus_ack_in, interrupt_request_five_in, output_disable_three_in} <= 3'h7;
		serial_zero_receive_in <= 1'b1;
	end
	else
	begin
		{pa3_pin_out, pa3_pin_oe} <= {pa3_out_d, pa3_oe_d};
		{pb6_pin_out, pb6_pin_oe} <= {pb6_out_d, pb6_oe_d};
		{pc5_pin_out, pc5_pin_oe} <= {pc5_out_d, pc5_oe_d};
		{pc4_pin_out, pc4_pin_oe} <= {pc4_out_d, pc4_oe_d};
		// Port inputs always see the pin; unselected peripherals idle high
		{pa3_port_in, pb6_port_in, pc5_port_in, pc4_port_in} <= {pa3_s, pb6_s, pc5_s, pc4_s};
		test_mode_select_in <= emu_sel_n_s | pa3_s;
		serial_one_receive_in <= !emu_sel_n_s | (pa3_fn != `CODE_FIVE) | pa3_s;
		sync_serial_data_in <= !emu_sel_n_s | (pa3_fn != `CODE_SEVEN) | pa3_s;
		bus_ack_in <= (pb6_fn != `CODE_TWO) | pb6_s;
		interrupt_request_five_in <= (pb6_fn != `CODE_THREE) | pb6_s;
		output_disable_three_in <= (pb6_fn != `CODE_FOUR) | pb6_s;
		serial_zero_receive_in <= (pb6_fn != `CODE_FIVE) | pb6_s;
	end
end

endmodule

// [tb/port_pin_function_select_assertions.sv]
// Port checker for the pin function selector
`timescale 1ns/100ps
module pin_function_checker
(
	input wire sys_clk,
	input wire rst_b,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire emulator_select_input_n,
	input wire pa3_pin_in,
	input wire pa3_pin_oe,
	input wire test_mode_select_in,
	input wire pc4_pin_in,
	input wire pc4_port_in
);
	// ----
	// Properties
	// ----
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_reserved_zero: assert property (
		s_axi_rvalid |-> (s_axi_rdata & 32'hFFFF8888) == 32'h00000000)
		else $error("reserved bits set");
	a_emu_undriven: assert property (
		(!emulator_select_input_n)[*6] |-> !pa3_pin_oe) else $error("pa3 driven");
	a_emu_test_pin: assert property (
		(!emulator_select_input_n && $stable(pa3_pin_in))[*6] |->
		test_mode_select_in == pa3_pin_in) else $error("test select wrong");
	a_port_in_tracks: assert property (
		$stable(pc4_pin_in)[*5] |-> pc4_port_in == pc4_pin_in) else $error("port in wrong");
endmodule

bind port_pin_function_select pin_function_checker i_pin_function_checker (.*);

// [tb/port_pin_function_select_tb.sv]
// Self-checking bench for the pin function selector
`timescale 1ns/100ps
`include "pin_function_defines.vh"
module port_pin_function_select_tb;
	logic sys_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, ext_rom_disabled_strap, emulator_select_input_n;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb, pins;
	logic [15:0] drv;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire pa3_pin_in, pb6_pin_in, pc5_pin_in, pc4_pin_in, pa3_pin_out, pa3_pin_oe;
	wire pb6_pin_out, pb6_pin_oe, pc5_pin_out, pc5_pin_oe, pc4_pin_out, pc4_pin_oe;
	wire pa3_port_in, pb6_port_in, pc5_port_in, pc4_port_in, pa3_port_out, pa3_port_oe;
	wire chip_select_three_out, sync_serial_data_out, sync_serial_data_oe, pb6_port_out;
	wire pb6_port_oe, address_bit_eighteen, output_disable_three_out, output_disable_three_oe;
	wire pc5_port_out, pc5_port_oe, address_bit_five, pc4_port_out, pc4_port_oe;
	wire address_bit_four, serial_one_receive_in, sync_serial_data_in, test_mode_select_in;
	wire bus_ack_in, interrupt_request_five_in, output_disable_three_in, serial_zero_receive_in;
	assign {address_bit_four, pc4_port_oe, pc4_port_out, address_bit_five, pc5_port_oe,
		pc5_port_out, output_disable_three_oe, output_disable_three_out, address_bit_eighteen,
		pb6_port_oe, pb6_port_out, sync_serial_data_oe, sync_serial_data_out,
		chip_select_three_out, pa3_port_oe, pa3_port_out} = drv;
	assign {pa3_pin_in, pb6_pin_in, pc5_pin_in, pc4_pin_in} = pins;
	wire [6:0] per = {serial_one_receive_in, sync_serial_data_in, test_mode_select_in,
		bus_ack_in, interrupt_request_five_in, output_disable_three_in, serial_zero_receive_in};
	wire [7:0] pst = {pa3_pin_out & pa3_pin_oe, pa3_pin_oe, pb6_pin_out & pb6_pin_oe,
		pb6_pin_oe, pc5_pin_out & pc5_pin_oe, pc5_pin_oe, pc4_pin_out & pc4_pin_oe, pc4_pin_oe};
	wire [3:0] pin_seen = {pa3_port_in, pb6_port_in, pc5_port_in, pc4_port_in};
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [4:0] ra[4] = '{5'h00, 5'h04, 5'h08, 5'h0C};
	logic [31:0] bx[4] = '{32'h0, 32'h11, 32'h100, 32'h11};
	logic [31:0] wm[4] = '{32'h7777, 32'h7777, 32'h500, 32'h11};
	typedef struct {logic [4:0] a; logic [15:0] d; logic [15:0] v; logic [3:0] pn; int p;
		logic [1:0] e; logic [6:0] q;} row_t;
	// Register, write data, drive, pins, pin index, pin state, peripheral inputs
	row_t rows[14] = '{
		'{5'h00, 16'h0000, 16'h0003, 4'hF, 0, 2'h3, 7'h7F},
		'{5'h00, 16'h1000, 16'h0004, 4'hF, 0, 2'h3, 7'h7F},
		'{5'h00, 16'h5000, 16'h0003, 4'h7, 0, 2'h0, 7'h3F},
		'{5'h00, 16'h7000, 16'h0018, 4'h7, 0, 2'h3, 7'h5F},
		'{5'h08, 16'h0000, 16'h0060, 4'hF, 1, 2'h3, 7'h7F},
		'{5'h08, 16'h0100, 16'h0080, 4'hF, 1, 2'h3, 7'h7F},
		'{5'h08, 16'h0200, 16'h0060, 4'hB, 1, 2'h0, 7'h77},
		'{5'h08, 16'h0300, 16'h0060, 4'hB, 1, 2'h0, 7'h7B},
		'{5'h08, 16'h0400, 16'h0300, 4'hB, 1, 2'h3, 7'h7D},
		'{5'h08, 16'h0500, 16'h0060, 4'hB, 1, 2'h0, 7'h7E},
		'{5'h0C, 16'h0000, 16'h0C00, 4'hD, 2, 2'h3, 7'h7F},
		'{5'h0C, 16'h0010, 16'h1000, 4'hF, 2, 2'h3, 7'h7F},
		'{5'h0C, 16'h0000, 16'h6000, 4'hE, 3, 2'h3, 7'h7F},
		'{5'h0C, 16'h0001, 16'h8000, 4'hF, 3, 2'h3, 7'h7F}};

	port_pin_function_select i_port_pin_function_select (.*);

	// ----
	// Tasks
	// ----
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [4:0] a, logic [31:0] d, logic [1:0] r);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", r, s_axi_bresp);
	endtask
	task automatic rd(logic [4:0] a, logic [31:0] e, logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", r, s_axi_rresp);
	endtask
	task automatic boot(logic s);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		ext_rom_disabled_strap <= s;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		do
			@(posedge sys_clk);
		while (!s_axi_awready);
		for (int i = 0; i < 4; i++)
			rd(ra[i], s ? bx[i] : 32'h0, `RESP_OKAY);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----
	// Clock, timeout, sequence
	// ----
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial
	begin
		rst_b = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 5'h00;
		s_axi_araddr = 5'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		ext_rom_disabled_strap = 1'b0;
		emulator_select_input_n = 1'b1;
		drv = 16'h0000;
		pins = 4'hF;
		boot(1'b1);
		boot(1'b0);
		for (int i = 0; i < 4; i++)
		begin
			wr(ra[i], wm[i], `RESP_OKAY);
			rd(ra[i], wm[i], `RESP_OKAY);
		end
		wr(5'h10, 32'h7, `RESP_OKAY);
		rd(5'h10, 32'h4, `RESP_OKAY);
		wr(5'h14, 32'h1, `RESP_SLVERR);
		rd(5'h14, 32'h0, `RESP_SLVERR);
		foreach (rows[i])
		begin
			wr(rows[i].a, {16'h0, rows[i].d}, `RESP_OKAY);
			drv <= rows[i].v;
			pins <= rows[i].pn;
			repeat (5) @(posedge sys_clk);
			chk("pin", rows[i].e, pst[7 - 2 * rows[i].p -: 2]);
			chk("periph", rows[i].q, per);
			chk("port_in", rows[i].pn, pin_seen);
		end
		wr(5'h00, 32'h1000, `RESP_OKAY);
		drv <= 16'h0004;
		pins <= 4'h7;
		emulator_select_input_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("pin", 32'h0, pst[7:6]);
		chk("periph", 32'h6F, per);
		emulator_select_input_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("pin", 32'h3, pst[7:6]);
		report_and_stop();
	end
endmodule
